// >>> csp_pkg.sv
/*
 * Package for the clocked serial port: I/O addresses, control register
 * field positions, reset values, divider figures and shared types.
 * Assumes an 8-bit processor I/O bus with one-cycle read/write strobes.
 */
`default_nettype none

package csp_pkg;

    localparam logic [7:0] CSP_ADDR_CTRL = 8'h0A;
    localparam logic [7:0] CSP_ADDR_DATA = 8'h0B;

    localparam int CSP_BIT_DONE = 7;
    localparam int CSP_BIT_IE   = 6;
    localparam int CSP_BIT_RX   = 5;
    localparam int CSP_BIT_TX   = 4;

    localparam logic       CSP_RST_DONE = 1'b0;
    localparam logic       CSP_RST_IE   = 1'b0;
    localparam logic       CSP_RST_GO   = 1'b0;
    localparam logic [2:0] CSP_RST_SS   = 3'h7;
    localparam logic [7:0] CSP_RST_DATA = 8'h00;

    localparam logic [2:0] CSP_SS_EXT   = 3'h7;
    localparam int         CSP_WORD_BITS = 8;
    localparam logic [2:0] CSP_LAST_BIT = 3'(CSP_WORD_BITS - 1);

    localparam int CSP_CLK_PERIOD_NS = 8;
    localparam int CSP_DIV_BASE      = 20;
    localparam logic [9:0] CSP_HALF_BASE = 10'(CSP_DIV_BASE / 2);

    typedef enum logic [1:0] {
        CSP_IDLE  = 2'b00,
        CSP_SHIFT = 2'b01
    } csp_phase_e;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } csp_io_req_s;

    typedef struct packed {
        logic serialIn;
        logic clockIn;
    } csp_pin_in_s;

    typedef struct packed {
        logic serialOut;
        logic clockOut;
        logic clockOe;
    } csp_pin_out_s;

    // half period of the internal data clock, in system clocks
    function automatic logic [9:0] cspHalfCount(input logic [2:0] sel);
        cspHalfCount = 10'(CSP_HALF_BASE << sel);
    endfunction

    function automatic logic cspIsInternal(input logic [2:0] sel);
        cspIsInternal = (sel != CSP_SS_EXT);
    endfunction

endpackage

`default_nettype wire

// >>> csp_clk_div.sv
/*
 * Internal data clock divider: one-cycle pulse every half period of the
 * selected rate while run is high. Restarts its count when run drops.
 */
`timescale 1ns/1ps
`default_nettype none

module csp_clk_div
    import csp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       run,
    input  wire logic [2:0] speedSel,
    output logic            halfTick
);

    typedef struct packed {
        logic [9:0] cnt;
        logic       tick;
    } csp_div_s;

    csp_div_s state_r;
    csp_div_s state_nxt;

    always_comb begin
        state_nxt = state_r;
        state_nxt.tick = 1'b0;
        if (!run) begin
            state_nxt.cnt = 10'h000;
        end else if (state_r.cnt >= cspHalfCount(speedSel) - 10'h001) begin
            state_nxt.cnt = 10'h000;
            state_nxt.tick = 1'b1;
        end else begin
            state_nxt.cnt = state_r.cnt + 10'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign halfTick = state_r.tick;

endmodule

`default_nettype wire

// >>> csp_port.sv
/*
 * Clocked serial port top: control/status and shift data registers on
 * the processor I/O bus, half-duplex 8-bit shifter, data clock pin.
 * Assumes bus strobes last one clock and pins are synchronous to clk.
 */
//
// Overview of operation
// R1 - half-duplex, fixed 8-bit words, internal or external data clock
// R2 - control/status at address 0AH: done, irq enable, rx go, tx go, speed
// R3 - done flag set when an 8-bit transfer completes; read-only
// R4 - interrupt request while done and enable both set, else none
// R5 - any read or write of shift data clears done
// R6 - software touches shift data only while done is set
// R7 - reset clears done, enable, both go bits; speed select all ones
// R8 - I/O stop mode clears done and both go bits
// R9 - writing rx go starts receive with data clock enabled on pin
// R10 - receive shifts serial input in; after 8 bits clears go, sets done
// R11 - writing tx go starts transmit with data clock enabled on pin
// R12 - transmit shifts serial output; after 8 bits clears go, sets done
// R13 - software never sets rx go and tx go together
// R14 - software frees the shared input pin from the channel 1 cts input
// R15 - speed select chooses data clock source and rate
// R16 - codes 0-6 divide by 20 to 1280; code 7 is external clock
// R17 - code 7 makes clock pin input; else output while transferring (code drives it as output whenever speed is 0-6, idle too)
// R18 - clearing a go bit stops that transfer at once
// R19 - one unbuffered shift register; writes mid-transfer take effect at once
// R20 - lsb first, output changes on falling, input sampled on rising edge
`timescale 1ns/1ps
`default_nettype none

module csp_port
    import csp_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire csp_io_req_s  ioReq,
    input  wire logic         io_stop_mode,
    input  wire csp_pin_in_s  pinIn,
    output logic [7:0]        ioRdData,
    output logic              irqReq,
    output csp_pin_out_s      pinOut
);

    typedef struct packed {
        csp_phase_e  phase;
        logic        done;
        logic        irqEn;
        logic        rxGo;
        logic        txGo;
        logic [2:0]  speed;
        logic [7:0]  shiftData;
        logic [2:0]  bitCnt;
        logic        sclk;
        logic        clkInPrev;
        logic [7:0]  rdData;
        logic        irq;
        logic [9:0]  tickGap;
        csp_pin_out_s pins;
    } csp_state_s;

    csp_state_s state_r;
    csp_state_s state_nxt;

    logic halfTick;
    logic active;
    logic ctrlWr;
    logic dataWr;
    logic dataRd;
    logic fallEdge;
    logic riseEdge;
    logic finish;
    logic divRun;

    default clocking cspCb @(posedge clk); endclocking
    default disable iff (!rst_b);

    assign active = state_r.rxGo | state_r.txGo;
    assign divRun = active && cspIsInternal(state_r.speed);
    assign ctrlWr = ioReq.wr && (ioReq.addr == CSP_ADDR_CTRL);
    assign dataWr = ioReq.wr && (ioReq.addr == CSP_ADDR_DATA);
    assign dataRd = ioReq.rd && (ioReq.addr == CSP_ADDR_DATA);

    csp_clk_div csp_clk_div_inst (
        .clk      (clk),
        .rst_b    (rst_b),
        .run      (divRun),
        .speedSel (state_r.speed),
        .halfTick (halfTick)
    );

    // edge source: divider ticks or the pin sampled against its last value
    always_comb begin
        fallEdge = 1'b0;
        riseEdge = 1'b0;
        if (state_r.phase == CSP_SHIFT) begin
            if (cspIsInternal(state_r.speed)) begin                // [R15] [R16]
                fallEdge = halfTick && state_r.sclk;
                riseEdge = halfTick && !state_r.sclk;
            end else begin
                fallEdge = state_r.clkInPrev && !pinIn.clockIn;
                riseEdge = !state_r.clkInPrev && pinIn.clockIn;
            end
        end
    end

    assign finish = riseEdge && (state_r.bitCnt == CSP_LAST_BIT);

    always_comb begin
        state_nxt = state_r;
        state_nxt.clkInPrev = pinIn.clockIn;

        // shifting: lsb first, drive on fall, sample on rise
        if (fallEdge) begin
            state_nxt.sclk = 1'b0;
            state_nxt.pins.serialOut = state_r.txGo ?                  // [R12]
                state_r.shiftData[0] : state_r.pins.serialOut;         // [R20]
        end
        if (riseEdge) begin
            state_nxt.sclk = 1'b1;
            state_nxt.bitCnt = state_r.bitCnt + 3'h1;
            state_nxt.shiftData = {pinIn.serialIn,                     // [R10]
                                   state_r.shiftData[7:1]};            // [R20]
        end
        if (finish) begin
            state_nxt.rxGo = 1'b0;                                     // [R10]
            state_nxt.txGo = 1'b0;                                     // [R12]
            state_nxt.phase = CSP_IDLE;
            state_nxt.bitCnt = 3'h0;
            state_nxt.sclk = 1'b1;
        end

        // shared data register; write lands even mid-shift
        if (dataWr) begin
            state_nxt.shiftData = ioReq.wdata;                         // [R19]
        end
        if (dataWr || dataRd) begin
            state_nxt.done = 1'b0;                                     // [R5]
        end
        if (finish) begin
            state_nxt.done = 1'b1;                                     // [R3]
        end

        if (ctrlWr) begin                                              // [R2]
            state_nxt.irqEn = ioReq.wdata[CSP_BIT_IE];
            state_nxt.speed = ioReq.wdata[2:0];
            state_nxt.rxGo = ioReq.wdata[CSP_BIT_RX];
            state_nxt.txGo = ioReq.wdata[CSP_BIT_TX];
            if ((!active || finish) &&                                 // [R9]
                (ioReq.wdata[CSP_BIT_RX] || ioReq.wdata[CSP_BIT_TX])) begin
                state_nxt.phase = CSP_SHIFT;                           // [R11]
                state_nxt.bitCnt = 3'h0;
                state_nxt.sclk = 1'b1;
            end
            if (!ioReq.wdata[CSP_BIT_RX] &&
                !ioReq.wdata[CSP_BIT_TX]) begin                        // [R18]
                state_nxt.phase = CSP_IDLE;
                state_nxt.bitCnt = 3'h0;
                state_nxt.sclk = 1'b1;
            end
        end

        if (io_stop_mode) begin                                              // [R8]
            state_nxt.done = 1'b0;
            state_nxt.rxGo = 1'b0;
            state_nxt.txGo = 1'b0;
            state_nxt.phase = CSP_IDLE;
            state_nxt.bitCnt = 3'h0;
            state_nxt.sclk = 1'b1;
        end

        if (ioReq.rd) begin
            case (ioReq.addr)
                CSP_ADDR_CTRL: begin
                    state_nxt.rdData = {state_r.done, state_r.irqEn,
                                        state_r.rxGo, state_r.txGo,
                                        1'b0, state_r.speed};
                end
                CSP_ADDR_DATA: begin
                    state_nxt.rdData = state_r.shiftData;
                end
                default: begin
                    state_nxt.rdData = 8'h00;
                end
            endcase
        end

        // independent tick spacing count for the rate check
        if (!divRun) begin
            state_nxt.tickGap = 10'h000;
        end else if (halfTick) begin
            state_nxt.tickGap = 10'h001;
        end else begin
            state_nxt.tickGap = state_r.tickGap + 10'h001;
        end

        state_nxt.irq = state_nxt.done && state_nxt.irqEn;             // [R4]
        state_nxt.pins.clockOe = cspIsInternal(state_nxt.speed);       // [R17]
        state_nxt.pins.clockOut = state_nxt.sclk;                      // [R1]
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r.phase <= CSP_IDLE;
            state_r.done <= CSP_RST_DONE;                              // [R7]
            state_r.irqEn <= CSP_RST_IE;
            state_r.rxGo <= CSP_RST_GO;
            state_r.txGo <= CSP_RST_GO;
            state_r.speed <= CSP_RST_SS;
            state_r.shiftData <= CSP_RST_DATA;
            state_r.bitCnt <= 3'h0;
            state_r.sclk <= 1'b1;
            state_r.clkInPrev <= 1'b1;
            state_r.rdData <= 8'h00;
            state_r.irq <= 1'b0;
            state_r.tickGap <= 10'h000;
            state_r.pins.serialOut <= 1'b1;
            state_r.pins.clockOut <= 1'b1;
            state_r.pins.clockOe <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign ioRdData = state_r.rdData;
    assign irqReq = state_r.irq;
    assign pinOut = state_r.pins;

    sequence sLastRise;
        riseEdge && (state_r.bitCnt == CSP_LAST_BIT);
    endsequence

    sequence sRxLast;
        state_r.rxGo ##0 sLastRise;
    endsequence

    sequence sTxLast;
        state_r.txGo ##0 sLastRise;
    endsequence

    sequence sQuiet;
        !ctrlWr && !io_stop_mode;
    endsequence

    sequence sGoWrite;
        ctrlWr && (ioReq.wdata[CSP_BIT_RX] || ioReq.wdata[CSP_BIT_TX]);
    endsequence

    a_irq_gate: assert property ( // [R4]
        irqReq == (state_r.done && state_r.irqEn))
        else $error("irq request does not follow done and enable");

    a_rx_finish: assert property ( // [R10]
        sRxLast ##0 sQuiet |=> !state_r.rxGo && state_r.done)
        else $error("receive did not end after the eighth bit");

    a_tx_finish: assert property ( // [R12]
        sTxLast ##0 sQuiet |=> !state_r.txGo && state_r.done)
        else $error("transmit did not end after the eighth bit");

    a_done_clear: assert property ( // [R5]
        (dataWr || dataRd) && !finish |=> !state_r.done)
        else $error("data access did not clear done");

    a_stop_clear: assert property ( // [R8]
        io_stop_mode |=> !state_r.done && !state_r.rxGo && !state_r.txGo)
        else $error("stop mode did not clear done and go bits");

    a_go_abort: assert property ( // [R18]
        ctrlWr && !ioReq.wdata[CSP_BIT_RX] && !ioReq.wdata[CSP_BIT_TX]
        |=> state_r.phase == CSP_IDLE && !active)
        else $error("clearing go did not stop the transfer");

    a_start_shift: assert property ( // [R9] [R11]
        sGoWrite ##0 (!active && !io_stop_mode) |=> state_r.phase == CSP_SHIFT)
        else $error("setting go did not start shifting");

    a_pin_dir: assert property ( // [R17]
        pinOut.clockOe == (state_r.speed != CSP_SS_EXT))
        else $error("clock pin direction does not follow speed select");

    a_idle_clock: assert property ( // [R17]
        state_r.phase == CSP_IDLE |-> pinOut.clockOut)
        else $error("clock pin not high between frames");

    a_lsb_out: assert property ( // [R20]
        fallEdge && state_r.txGo
        |=> pinOut.serialOut == $past(state_r.shiftData[0]))
        else $error("serial output is not the low shift bit");

    a_rx_quiet: assert property ( // [R10]
        fallEdge && !state_r.txGo |=> $stable(pinOut.serialOut))
        else $error("serial output moved while not transmitting");

    a_lsb_in: assert property ( // [R20] [R10]
        riseEdge && !dataWr |=> state_r.shiftData[7] == $past(pinIn.serialIn))
        else $error("serial input not taken into the top bit");

    a_bit_step: assert property ( // [R1]
        riseEdge && !finish && !ctrlWr && !io_stop_mode
        |=> state_r.bitCnt == $past(state_r.bitCnt) + 3'h1)
        else $error("bit counter did not advance on a rising edge");

    a_half_rate: assert property ( // [R16]
        halfTick |-> state_r.tickGap == cspHalfCount(state_r.speed))
        else $error("data clock half period does not match speed select");

endmodule

`default_nettype wire

// >>> csp_peer.sv
/*
 * Far-side serial peer: samples the port's output on rising clock,
 * presents its own byte lsb first, changing on falling clock.
 * Assumes the bench resolves the clock pin and pulses start per frame.
 */
`timescale 1ns/1ps
`default_nettype none

module csp_peer #(
    parameter int HALF_NS = 200
) (
    input  wire logic       pinClk,
    input  wire logic       serialOut,
    input  wire logic       start,
    input  wire logic       extMode,
    input  wire logic [7:0] txByte,
    output logic            serialIn,
    output logic            extClk,
    output logic [7:0]      rxByte
);
    int   idx;
    logic rose;

    initial begin
        extClk = 1'b1;
        serialIn = 1'b1;
        rxByte = 8'h00;
        idx = 8;
        rose = 1'b0;
    end

    // clock stands high between frames
    always @(posedge start) begin
        // step off the port's sampling edge
        #1;
        idx = 0;
        rose = 1'b0;
        serialIn = txByte[0];
        if (extMode) begin
            repeat (8) begin
                #HALF_NS extClk = 1'b0;
                #HALF_NS extClk = 1'b1;
            end
        end
    end

    always @(posedge pinClk) begin
        rxByte = {serialOut, rxByte[7:1]};
        rose = 1'b1;
    end

    // released line shows the inverse of its last bit
    always @(negedge pinClk) begin
        if (rose && idx < 8) begin
            idx++;
            serialIn = (idx < 8) ? txByte[idx] : ~serialIn;
        end
    end
endmodule

`default_nettype wire

// >>> tb_clocked_serial_port.sv
/*
 * Self-checking bench for the clocked serial port with a peer model.
 * Assumes one-cycle bus strobes and read data valid after the strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_clocked_serial_port
    import csp_pkg::*;
;
    logic         clk = 1'b0;
    logic         rst_b = 1'b0;
    csp_io_req_s  ioReq = '0;
    logic         io_stop_mode = 1'b0;
    csp_pin_in_s  pinIn;
    logic [7:0]   ioRdData;
    logic         irqReq;
    csp_pin_out_s pinOut;
    logic         pinClk;
    logic         extClk;
    logic         serialIn;
    logic         start = 1'b0;
    logic         extMode = 1'b0;
    logic [7:0]   txByte = 8'h00;
    logic [7:0]   rxByte;
    int           failures = 0;
    int           checks_done = 0;

    assign pinClk = pinOut.clockOe ? pinOut.clockOut : extClk;
    assign pinIn = '{serialIn: serialIn, clockIn: pinClk};

    always #4 clk = ~clk;

    csp_port csp_port_inst (.clk(clk), .rst_b(rst_b), .ioReq(ioReq),
        .io_stop_mode(io_stop_mode), .pinIn(pinIn), .ioRdData(ioRdData),
        .irqReq(irqReq), .pinOut(pinOut));

    csp_peer csp_peer_inst (.pinClk(pinClk), .serialOut(pinOut.serialOut),
        .start(start), .extMode(extMode), .txByte(txByte),
        .serialIn(serialIn), .extClk(extClk), .rxByte(rxByte));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask

    task automatic ioWr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        ioReq <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk);
        ioReq.wr <= 1'b0;
    endtask

    task automatic ioRd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        ioReq <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk);
        ioReq.rd <= 1'b0;
        #1 d = ioRdData;
    endtask

    task automatic chkCtrl(input logic [7:0] e);
        logic [7:0] d;
        ioRd(CSP_ADDR_CTRL, d);
        chk("ctrl", {8'h00, e}, {8'h00, d & 8'hF7});
    endtask

    task automatic waitIrq(input int lim);
        for (int i = 0; i < lim && irqReq !== 1'b1; i++) @(posedge clk);
        #1;
    endtask

    // cycles between two rising edges of the driven clock pin
    task automatic riseGap(output int gap);
        int   t0;
        logic prev;
        t0 = -1;
        gap = 0;
        prev = pinOut.clockOut;
        for (int n = 0; n < 3000 && gap == 0; n++) begin
            @(posedge clk);
            #1;
            if (pinOut.clockOut === 1'b1 && prev === 1'b0) begin
                if (t0 < 0) t0 = n;
                else gap = n - t0;
            end
            prev = pinOut.clockOut;
        end
    endtask

    task automatic testReset();
        chkCtrl(8'h07);
        chk("irq", 16'h0000, {15'h0, irqReq});
        chk("oe", 16'h0000, {15'h0, pinOut.clockOe});
        $display("reset test done");
    endtask

    task automatic testRates();
        int gap;
        for (int s = 0; s < 7; s++) begin
            ioWr(CSP_ADDR_CTRL, 8'h10 | 8'(s));
            riseGap(gap);
            chk("period", 16'(16'h14 << s), 16'(gap));
            chk("oe", 16'h0001, {15'h0, pinOut.clockOe});
            ioWr(CSP_ADDR_CTRL, 8'(s));
            chkCtrl(8'(s));
        end
        $display("rate test done");
    endtask

    task automatic testTx();
        logic [7:0] d;
        ioWr(CSP_ADDR_DATA, 8'hA5);
        ioWr(CSP_ADDR_CTRL, 8'h50);
        waitIrq(400);
        chk("irq", 16'h0001, {15'h0, irqReq});
        chk("peer rx", 16'h00A5, {8'h00, rxByte});
        chkCtrl(8'hC0);
        ioWr(CSP_ADDR_CTRL, 8'h80);
        chkCtrl(8'h80);
        chk("irq masked", 16'h0000, {15'h0, irqReq});
        ioRd(CSP_ADDR_DATA, d);
        chkCtrl(8'h00);
        $display("transmit test done");
    endtask

    task automatic testMidWrite();
        logic [7:0] d;
        ioWr(CSP_ADDR_DATA, 8'h96);
        ioWr(CSP_ADDR_CTRL, 8'h50);
        repeat (4) @(posedge pinOut.clockOut);
        ioWr(CSP_ADDR_DATA, 8'h3A);
        waitIrq(400);
        chk("irq", 16'h0001, {15'h0, irqReq});
        chk("mixed rx", 16'h00A6, {8'h00, rxByte});
        ioRd(CSP_ADDR_DATA, d);
        chkCtrl(8'h40);
        $display("mid-transfer write test done");
    endtask

    task automatic testRx();
        logic [7:0] d;
        extMode <= 1'b1;
        txByte <= 8'h3C;
        ioWr(CSP_ADDR_CTRL, 8'h67);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (100) @(posedge clk);
        chk("oe ext", 16'h0000, {15'h0, pinOut.clockOe});
        waitIrq(1000);
        chk("irq", 16'h0001, {15'h0, irqReq});
        chkCtrl(8'hC7);
        ioRd(CSP_ADDR_DATA, d);
        chk("rx data", 16'h003C, {8'h00, d});
        chkCtrl(8'h47);
        $display("receive test done");
    endtask

    task automatic testStop();
        extMode <= 1'b0;
        ioWr(CSP_ADDR_CTRL, 8'h26);
        repeat (50) @(posedge clk);
        io_stop_mode <= 1'b1;
        @(posedge clk);
        io_stop_mode <= 1'b0;
        chkCtrl(8'h06);
        $display("stop test done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        testReset();
        testRates();
        testTx();
        testMidWrite();
        testRx();
        testStop();
        end_sim();
    end

    initial begin
        #200000;
        failures++;
        end_sim();
    end
endmodule

`default_nettype wire
